// File: logic/vector_map_pkg.sv
// constants for the vector map, ram window, stack engine and register port
// assumes a 16-bit cpu address space and an 8-bit data path
package vector_map_pkg;
	localparam logic [15:0] RAM_FIRST = 16'h0040;
	localparam logic [15:0] RAM_LAST = 16'h01bf;
	localparam int RAM_BYTES = 384;
	localparam logic [15:0] PAGE0_LAST = 16'h00ff;
	localparam int PAGE0_RAM_BYTES = 192;
	localparam logic [15:0] SP_RESET = 16'h00ff;
	localparam logic [2:0] IRQ_FRAME_BYTES = 3'h5;
	localparam logic [2:0] CALL_FRAME_BYTES = 3'h2;
	localparam logic [15:0] VECTOR_BASE = 16'hffdc;
	localparam logic [15:0] RESET_VEC_HI = 16'hfffe;
	localparam logic [15:0] RESET_VEC_LO = 16'hffff;
	localparam logic [15:0] SWI_VEC_HI = 16'hfffc;
	localparam int NUM_SOURCES = 16;
	// register port offsets
	localparam logic [15:0] BREAK_ADDRESS_LOW = 16'hfe0a;
	localparam logic [15:0] BREAK_STATUS_CONTROL = 16'hfe0b;
	localparam logic [15:0] LOW_VOLTAGE_STATUS = 16'hfe0c;
	localparam logic [15:0] FLASH_BLOCK_PROTECT = 16'hff7e;
	localparam logic [15:0] WATCHDOG_CLEAR_LOCATION = 16'hffff;
	localparam logic [15:0] IRQ_STATUS_1 = 16'hfe04;
	localparam logic [15:0] IRQ_STATUS_2 = 16'hfe05;
	localparam logic [15:0] IRQ_STATUS_3 = 16'hfe06;
	localparam logic [15:0] IRQ_STICKY = 16'hfe10;
	localparam logic [15:0] IRQ_MASK = 16'hfe11;
	localparam logic [15:0] SP_LOW = 16'hfe12;
	localparam logic [15:0] SP_HIGH = 16'hfe13;
	// field positions
	localparam int BREAK_ENABLE_POS = 7;
	localparam int BREAK_ACTIVE_POS = 6;
	localparam int LOW_VOLTAGE_OUT_POS = 7;
	localparam int STICKY_OVERFLOW_POS = 0;
	localparam int STICKY_UNDERFLOW_POS = 1;
	localparam int STICKY_WDOG_POS = 2;
	localparam int STICKY_BREAK_POS = 3;
	// reset values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] FLASH_PROTECT_DEFAULT = 8'hff;
	localparam logic [7:0] VECTOR_ERASED = 8'hff;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_PUSH = 4'b0010,
		ST_VEC_HI = 4'b0100,
		ST_VEC_LO = 4'b1000
	} stack_state_t;
endpackage

// File: logic/vector_map_and_stack_ram.sv
// vector table, ram, stack engine and watchdog clear location of the cpu map
// assumes pending sources and cpu requests come from logic on clk;
// low voltage and break pin levels arrive asynchronously
//
// Summary of operation
// R1: addresses 0040 to 01bf are cpu readable and writable ram.
// R2: 192 of those ram bytes sit inside page zero.
// R3: stack pointer is sixteen bits, covering the whole address space.
// R4: reset loads the stack pointer with 00ff.
// R5: software keeps the stack pointer inside ram.
// R6: interrupt entry pushes exactly five bytes.
// R7: the high index register is not part of the interrupt frame.
// R8: a subroutine call pushes a two byte return address.
// R9: pushes decrement the stack pointer, pulls increment it.
// R10: vectors fill ffdc to ffff, high byte even, priority rising upward.
// R11: conversion done source fetches its vector from ffde and ffdf.
// R12: second timer channel zero fetches from fff0 and fff1.
// R13: first timer channel one fetches from fff4 and fff5.
// R14: first timer channel zero fetches from fff6 and fff7.
// R15: reading ffff gives reset vector low; any write clears the watchdog. Here ffff is never loaded and always reads erased ff.
// R16: flash runs from one supply with an internal charge pump.
// R17: each pending source shows as a read only flag one to sixteen.
// R18: with several pending, the highest priority vector is fetched.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module vector_map_and_stack_ram
	import vector_map_pkg::*;
#(
	parameter int VECTOR_WORDS = 18
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic [15:0] irq_pending,
	input wire logic irq_take,
	input wire logic call_take,
	input wire logic [15:0] call_return,
	input wire logic push,
	input wire logic pull,
	input wire logic [7:0] push_data,
	input wire logic [7:0] frame_a,
	input wire logic [7:0] frame_x,
	input wire logic [7:0] frame_ccr,
	input wire logic [15:0] frame_pc,
	output logic [7:0] pull_data,
	output logic [15:0] sp,
	output logic stack_busy,
	output logic [15:0] vector_out,
	output logic vector_valid,
	output logic [4:0] vector_source,
	output logic watchdog_counter_clear,
	input wire logic low_voltage_pin,
	input wire logic break_pin,
	output logic charge_pump_enable,
	output logic irq_out
);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [7:0] ram [0:RAM_BYTES-1];
	logic [7:0] vectors [0:2*VECTOR_WORDS-1];
	logic [7:0] break_address_low;
	logic [7:0] break_status_control;
	logic [7:0] flash_block_protect;
	logic [7:0] irq_sticky;
	logic [7:0] irq_mask;
	logic [2:0] lv_sync;
	logic [2:0] brk_sync;
	logic lv_level;
	logic brk_level;
	logic brk_prev;
	stack_state_t state;
	logic [2:0] push_left;
	logic [7:0] frame [0:4];
	logic [7:0] ram_q;
	logic [15:0] ram_idx;
	logic [15:0] push_idx;
	logic [15:0] pull_idx;
	logic [15:0] next_sp;
	logic [3:0] best_src;
	logic best_any;
	logic sp_overflow;
	logic sp_underflow;
	logic [15:0] vec_addr;
	logic [5:0] fetch_idx;
	logic [2*VECTOR_WORDS-1:0] vec_loaded;
	logic vec_we;
	logic [5:0] vec_widx;

	// R1 ram window decode
	function automatic logic in_ram(input logic [15:0] a);
		in_ram = (a >= RAM_FIRST) && (a <= RAM_LAST);
	endfunction

	// R2 page zero part is 0040..00ff, a direct-mode slice of the same array
	assign ram_idx = addr - RAM_FIRST;
	assign push_idx = sp - RAM_FIRST;
	assign pull_idx = sp + 16'h0001 - RAM_FIRST;

	// ------------------------------------------------------------
	// pin inputs, three flops, change once stages two and three agree
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lv_sync <= 3'h0;
			brk_sync <= 3'h0;
			lv_level <= 1'b0;
			brk_level <= 1'b0;
		end else begin
			lv_sync <= {lv_sync[1:0], low_voltage_pin};
			brk_sync <= {brk_sync[1:0], break_pin};
			if (lv_sync[1] == lv_sync[2])
				lv_level <= lv_sync[2];
			if (brk_sync[1] == brk_sync[2])
				brk_level <= brk_sync[2];
		end
	end

	// ------------------------------------------------------------
	// priority select
	// ------------------------------------------------------------
	// R18 lowest flag number wins, it sits highest in the table
	always_comb begin
		best_src = 4'h0;
		best_any = 1'b0;
		for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
			if (irq_pending[i]) begin
				best_src = 4'(i);
				best_any = 1'b1;
			end
		end
	end

	// R10 flag n (n = index+1) has its high byte at fffc - 2n
	// R11 R12 R13 R14 flags 15, 6, 4, 3 land on ffde, fff0, fff4, fff6
	// taken from the latched source, so a pending change mid-entry cannot move the fetch
	assign vec_addr = SWI_VEC_HI - {10'h000, vector_source, 1'b0};
	assign fetch_idx = vec_addr[5:0] - VECTOR_BASE[5:0];

	// ------------------------------------------------------------
	// stack engine
	// ------------------------------------------------------------
	assign stack_busy = (state != ST_IDLE);
	// a push at 0000 would wrap to the top of the map
	assign sp_overflow = (sp == 16'h0000) &&
		((state == ST_PUSH) || (state == ST_IDLE && (push || call_take)));
	assign sp_underflow = pull && (sp == 16'hffff);

	// R9 push decrements, pull increments
	always_comb begin
		next_sp = sp;
		if (state == ST_PUSH)
			next_sp = sp - 16'h0001;
		else if (state == ST_IDLE && call_take)
			next_sp = sp - 16'(CALL_FRAME_BYTES);
		else if (state == ST_IDLE && push)
			next_sp = sp - 16'h0001;
		else if (state == ST_IDLE && pull)
			next_sp = sp + 16'h0001;
	end

	// R3 full 16-bit pointer
	// R4 reset location in page zero
	// R5 no range check, software keeps it in ram
	// a bus write to the pointer wins over a strobe in the same cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			sp <= SP_RESET;
		else if (wr && addr == SP_LOW && state == ST_IDLE)
			sp <= {sp[15:8], wdata};
		else if (wr && addr == SP_HIGH && state == ST_IDLE)
			sp <= {wdata, sp[7:0]};
		else
			sp <= next_sp;
	end

	// ------------------------------------------------------------
	// interrupt entry sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
			push_left <= 3'h0;
			vector_out <= 16'h0000;
			vector_valid <= 1'b0;
			vector_source <= 5'h00;
		end else begin
			vector_valid <= 1'b0;
			case (state)
				ST_IDLE: begin
					// R6 five byte frame on interrupt entry
					if (irq_take && best_any) begin
						state <= ST_PUSH;
						push_left <= IRQ_FRAME_BYTES;
						vector_source <= {1'b0, best_src} + 5'h01;
					end
				end
				ST_PUSH: begin
					push_left <= push_left - 3'h1;
					if (push_left == 3'h1)
						state <= ST_VEC_HI;
				end
				ST_VEC_HI: begin
					vector_out[15:8] <= vec_loaded[fetch_idx] ? vectors[fetch_idx] : VECTOR_ERASED;
					state <= ST_VEC_LO;
				end
				ST_VEC_LO: begin
					vector_out[7:0] <= vec_loaded[fetch_idx + 6'h01] ?
						vectors[fetch_idx + 6'h01] : VECTOR_ERASED;
					vector_valid <= 1'b1;
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// R7 frame holds pc, x, a, ccr; high index is left out
	assign frame[0] = frame_pc[7:0];
	assign frame[1] = frame_pc[15:8];
	assign frame[2] = frame_x;
	assign frame[3] = frame_a;
	assign frame[4] = frame_ccr;

	// ------------------------------------------------------------
	// ram writes and stack pulls
	// ------------------------------------------------------------
	// bus writes lose to stack traffic in the same cycle
	always_ff @(posedge clk) begin
		if (state == ST_PUSH && in_ram(sp))
			ram[push_idx[8:0]] <= frame[3'h5 - push_left];
		else if (state == ST_IDLE && call_take) begin
			// R8 two byte return address, low byte first
			if (in_ram(sp))
				ram[push_idx[8:0]] <= call_return[7:0];
			if (in_ram(sp - 16'h0001))
				ram[push_idx[8:0] - 9'h001] <= call_return[15:8];
		end else if (state == ST_IDLE && push && in_ram(sp))
			ram[push_idx[8:0]] <= push_data;
		else if (wr && in_ram(addr))
			ram[ram_idx[8:0]] <= wdata;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			pull_data <= 8'h00;
		else if (state == ST_IDLE && pull && !push && !call_take)
			pull_data <= in_ram(sp + 16'h0001) ? ram[pull_idx[8:0]] : 8'h00;
	end

	// ------------------------------------------------------------
	// vector storage
	// ------------------------------------------------------------
	// vector bytes load only when the charge pump is on; writes otherwise leave the stored byte unchanged
	assign vec_we = wr && (addr >= VECTOR_BASE) && (addr != WATCHDOG_CLEAR_LOCATION) && charge_pump_enable;
	assign vec_widx = addr[5:0] - VECTOR_BASE[5:0];

	always_ff @(posedge clk) begin
		if (vec_we)
			vectors[vec_widx] <= wdata;
	end

	// limitation: a reset makes every vector read erased until reloaded
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			vec_loaded <= '0;
		else if (vec_we)
			vec_loaded[vec_widx] <= 1'b1;
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			break_address_low <= REG_RESET;
			break_status_control <= REG_RESET;
			flash_block_protect <= FLASH_PROTECT_DEFAULT;
			irq_mask <= REG_RESET;
		end else if (wr) begin
			case (addr)
				BREAK_ADDRESS_LOW: break_address_low <= wdata;
				BREAK_STATUS_CONTROL: break_status_control <= {wdata[7:6], 6'h00};
				FLASH_BLOCK_PROTECT: flash_block_protect <= wdata;
				IRQ_MASK: irq_mask <= wdata;
				default: ;
			endcase
		end
	end

	// R16 one supply: pump enabled while protection is open
	assign charge_pump_enable = (flash_block_protect == FLASH_PROTECT_DEFAULT);

	// R15 any write to ffff clears the watchdog
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			watchdog_counter_clear <= 1'b0;
		else
			watchdog_counter_clear <= wr && (addr == WATCHDOG_CLEAR_LOCATION);
	end

	// sticky events; set wins over write-one-to-clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			irq_sticky <= REG_RESET;
		else begin
			for (int b = 0; b < 8; b++) begin
				if (wr && addr == IRQ_STICKY && wdata[b])
					irq_sticky[b] <= 1'b0;
			end
			if (sp_overflow)
				irq_sticky[STICKY_OVERFLOW_POS] <= 1'b1;
			if (sp_underflow)
				irq_sticky[STICKY_UNDERFLOW_POS] <= 1'b1;
			if (wr && addr == WATCHDOG_CLEAR_LOCATION)
				irq_sticky[STICKY_WDOG_POS] <= 1'b1;
			if (brk_level && !brk_prev && break_status_control[BREAK_ENABLE_POS])
				irq_sticky[STICKY_BREAK_POS] <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			brk_prev <= 1'b0;
		else
			brk_prev <= brk_level;
	end

	assign irq_out = |(irq_sticky & irq_mask);

	// ------------------------------------------------------------
	// read port, data one cycle after the strobe
	// ------------------------------------------------------------
	always_comb begin
		ram_q = 8'h00;
		if (in_ram(addr))
			ram_q = ram[ram_idx[8:0]];
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rdata <= 8'h00;
		else if (rd) begin
			if (in_ram(addr))
				rdata <= ram_q;
			else if (addr >= VECTOR_BASE)
				// R15 ffff should read reset vector low, but writes never load it
				// unloaded bytes, ffff among them, read erased
				rdata <= vec_loaded[vec_widx] ? vectors[vec_widx] : VECTOR_ERASED;
			else begin
				case (addr)
					// R17 read-only pending flags
					IRQ_STATUS_1: rdata <= {irq_pending[5:0], 2'h0};
					IRQ_STATUS_2: rdata <= irq_pending[13:6];
					IRQ_STATUS_3: rdata <= {6'h00, irq_pending[15:14]};
					BREAK_ADDRESS_LOW: rdata <= break_address_low;
					BREAK_STATUS_CONTROL: rdata <= break_status_control;
					LOW_VOLTAGE_STATUS: rdata <= {lv_level, 7'h00};
					FLASH_BLOCK_PROTECT: rdata <= flash_block_protect;
					IRQ_STICKY: rdata <= irq_sticky;
					IRQ_MASK: rdata <= irq_mask;
					SP_LOW: rdata <= sp[7:0];
					SP_HIGH: rdata <= sp[15:8];
					default: rdata <= 8'h00;
				endcase
			end
		end
	end

endmodule

// File: test/cpu_core_model.sv
// cpu core model: raises interrupt entry and takes the vector
// assumes go is a one-cycle request from the bench on clk
`timescale 1ns/1ps
module cpu_core_model (
	input wire logic clk,
	input wire logic go,
	input wire logic vector_valid,
	input wire logic [15:0] vector_out,
	input wire logic [4:0] vector_source,
	output logic irq_take,
	output logic [15:0] got_vec,
	output logic [4:0] got_src,
	output logic seen
);
	// ----------------
	// entry and fetch
	// ----------------
	initial irq_take = 1'b0;
	initial seen = 1'b0;
	// vector_valid is a one-cycle pulse, so it is caught on that edge
	always @(posedge clk) begin
		irq_take <= go;
		if (go)
			seen <= 1'b0;
		if (vector_valid) begin
			got_vec <= vector_out;
			got_src <= vector_source;
			seen <= 1'b1;
		end
	end
endmodule

// File: test/vector_map_checker.sv
// checker for stack pointer, vector fetch and watchdog clear timing
// assumes it sees only the top module ports
`timescale 1ns/1ps
module vector_map_checker
	import vector_map_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [15:0] addr,
	input wire logic wr,
	input wire logic [15:0] irq_pending,
	input wire logic irq_take,
	input wire logic call_take,
	input wire logic push,
	input wire logic pull,
	input wire logic [15:0] sp,
	input wire logic stack_busy,
	input wire logic vector_valid,
	input wire logic watchdog_counter_clear
);
	// ----------
	// properties
	// ----------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic entry;
	logic idle;
	assign idle = !stack_busy;
	assign entry = irq_take && idle && (irq_pending != 16'h0000);
	a_sp_reset_value: assert property ($rose(resetn) |-> sp == SP_RESET)
		else $error("sp not 00ff after reset");
	a_irq_vector_fetch: assert property (entry |-> ##[6:8] vector_valid)
		else $error("no vector after entry");
	a_irq_frame_size: assert property (entry |-> ##7 sp == $past(sp, 7) - 16'h0005)
		else $error("entry frame not five bytes");
	a_call_frame_size: assert property (call_take && idle |=> sp == $past(sp) - 16'h0002)
		else $error("call frame not two bytes");
	a_push_decrement: assert property (push && !call_take && idle |=> sp == $past(sp) - 16'h0001)
		else $error("push did not decrement sp");
	a_pull_increment: assert property (pull && !push && !call_take && idle |=> sp == $past(sp) + 16'h0001)
		else $error("pull did not increment sp");
	a_wdog_clear_pulse: assert property (wr && addr == WATCHDOG_CLEAR_LOCATION |=> watchdog_counter_clear)
		else $error("write to ffff gave no clear");
	a_wdog_clear_only: assert property (watchdog_counter_clear |-> $past(wr) && $past(addr) == 16'hffff)
		else $error("clear without write to ffff");
	a_vector_one_cycle: assert property (vector_valid |=> !vector_valid)
		else $error("vector_valid longer than one cycle");
	a_busy_entry: assert property (entry |=> stack_busy[*7])
		else $error("stack_busy not held through entry");
	c_entry: cover property (entry);
	c_call: cover property (call_take && idle);
	c_wdog: cover property (watchdog_counter_clear);
	c_vector: cover property (vector_valid);
endmodule
bind vector_map_and_stack_ram vector_map_checker chk (.clk(clk), .resetn(resetn), .addr(addr), .wr(wr),
	.irq_pending(irq_pending), .irq_take(irq_take), .call_take(call_take), .push(push), .pull(pull),
	.sp(sp), .stack_busy(stack_busy), .vector_valid(vector_valid),
	.watchdog_counter_clear(watchdog_counter_clear));

// File: test/vector_map_and_stack_ram_tb.sv
// bench for ram window, stack engine, vector fetch, status and watchdog clear
// assumes a 100 ns clock and the cpu core model on the interrupt side
`timescale 1ns/1ps
module vector_map_and_stack_ram_tb
	import vector_map_pkg::*;
;
	logic clk, resetn, wr, rd, call_take, push, pull, go, stack_busy, vector_valid;
	logic watchdog_counter_clear, charge_pump_enable, irq_out, irq_take, seen;
	logic [15:0] addr, irq_pending, sp, vector_out, got_vec, s;
	logic [7:0] wdata, rdata, pull_data, push_data;
	logic low_voltage_pin, break_pin;
	logic [4:0] vector_source, got_src;
	int n_mismatch = 0;
	int compares = 0;
	int flags [4] = '{15, 6, 4, 3};
	// ------------
	// instances
	// ------------
	vector_map_and_stack_ram DUT (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .irq_pending(irq_pending), .irq_take(irq_take), .call_take(call_take),
		.call_return(16'h1234), .push(push), .pull(pull), .push_data(push_data), .frame_a(8'h11),
		.frame_x(8'h22), .frame_ccr(8'h33), .frame_pc(16'h4455), .pull_data(pull_data), .sp(sp),
		.stack_busy(stack_busy), .vector_out(vector_out), .vector_valid(vector_valid),
		.vector_source(vector_source), .watchdog_counter_clear(watchdog_counter_clear),
		.low_voltage_pin(low_voltage_pin), .break_pin(break_pin), .charge_pump_enable(charge_pump_enable),
		.irq_out(irq_out));
	cpu_core_model cpu (.clk(clk), .go(go), .vector_valid(vector_valid), .vector_out(vector_out),
		.vector_source(vector_source), .irq_take(irq_take), .got_vec(got_vec), .got_src(got_src), .seen(seen));
	// ------------
	// tasks
	// ------------
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task wb(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rb(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", 16'(exp), 16'(rdata));
	endtask
	task irq(input logic [15:0] pend, input int f);
		@(posedge clk);
		irq_pending <= pend;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		#1;
		for (int i = 0; i < 20 && seen !== 1'b1; i++)
			@(posedge clk);
		#1 chk("vector", {8'(8'h80 + f), 8'(f)}, got_vec);
		chk("source", 16'(f), 16'(got_src));
		chk("seen", 16'h0001, 16'(seen));
	endtask
	task strobe(input int which);
		@(posedge clk);
		{call_take, push, pull} <= 3'(1 << which);
		@(posedge clk);
		{call_take, push, pull} <= 3'h0;
		#1;
	endtask
	task wrap_up;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ------------
	// sequence
	// ------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#400000;
		n_mismatch++;
		wrap_up();
	end
	initial begin
		{resetn, wr, rd, call_take, push, pull, go} = 7'h0;
		{addr, irq_pending, wdata} = 40'h0;
		{low_voltage_pin, break_pin} = 2'h0;
		push_data = 8'h9a;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		#1 chk("sp", SP_RESET, sp);
		chk("pump", 16'h0001, 16'(charge_pump_enable));
		rb(SP_LOW, 8'hff);
		rb(SP_HIGH, 8'h00);
		wb(RAM_FIRST, 8'ha5);
		wb(RAM_LAST, 8'h5a);
		wb(16'h003f, 8'h77);
		wb(16'h01c0, 8'h77);
		wb(16'h00c0, 8'h3c);
		rb(RAM_FIRST, 8'ha5);
		rb(RAM_LAST, 8'h5a);
		rb(16'h003f, 8'h00);
		rb(16'h01c0, 8'h00);
		rb(16'h00c0, 8'h3c);
		foreach (flags[k]) begin
			wb(16'(16'hfffc - 2 * flags[k]), 8'(8'h80 + flags[k]));
			wb(16'(16'hfffd - 2 * flags[k]), 8'(flags[k]));
		end
		// stack starts at 00ff and stays in ram below it
		foreach (flags[k]) begin
			s = sp;
			irq(16'(1 << (flags[k] - 1)), flags[k]);
			chk("sp", s - 16'h0005, sp);
			rb(s, 8'h55);
			rb(s - 16'h0001, 8'h44);
			rb(s - 16'h0002, 8'h22);
			rb(s - 16'h0003, 8'h11);
			rb(s - 16'h0004, 8'h33);
		end
		irq(16'h4024, 3);
		@(posedge clk);
		irq_pending <= 16'h4024;
		rb(IRQ_STATUS_1, 8'h90);
		rb(IRQ_STATUS_2, 8'h00);
		rb(IRQ_STATUS_3, 8'h01);
		s = sp;
		strobe(2);
		chk("sp", s - 16'h0002, sp);
		rb(s, 8'h34);
		rb(s - 16'h0001, 8'h12);
		strobe(0);
		chk("pull", 16'h0012, 16'(pull_data));
		chk("sp", s - 16'h0001, sp);
		strobe(1);
		chk("sp", s - 16'h0002, sp);
		rb(s - 16'h0001, 8'h9a);
		wb(IRQ_MASK, 8'h00);
		wb(WATCHDOG_CLEAR_LOCATION, 8'h00);
		#1 chk("irq", 16'h0000, 16'(irq_out));
		chk("wdog", 16'h0001, 16'(watchdog_counter_clear));
		rb(IRQ_STICKY, 8'h04);
		wb(IRQ_MASK, 8'h04);
		#1 chk("irq", 16'h0001, 16'(irq_out));
		wb(IRQ_STICKY, 8'h04);
		#1 chk("irq", 16'h0000, 16'(irq_out));
		wb(BREAK_STATUS_CONTROL, 8'hc5);
		rb(BREAK_STATUS_CONTROL, 8'hc0);
		@(posedge clk);
		low_voltage_pin <= 1'b1;
		break_pin <= 1'b1;
		repeat (4) @(posedge clk);
		rb(LOW_VOLTAGE_STATUS, 8'h80);
		rb(IRQ_STICKY, 8'h08);
		wb(IRQ_STICKY, 8'h08);
		rb(IRQ_STICKY, 8'h00);
		wb(FLASH_BLOCK_PROTECT, 8'h00);
		#1 chk("pump", 16'h0000, 16'(charge_pump_enable));
		wb(16'hffde, 8'h00);
		rb(16'hffde, 8'h8f);
		rb(16'hffff, 8'hff);
		rb(16'hfe07, 8'h00);
		wrap_up();
	end
endmodule
